// ===== src/ivn_pkg.sv
/*
 * Package of the interrupt vector and nesting unit: register offsets, field
 * positions, reset values, timing counts and the carrier types.
 * Assumes a 10 MHz instruction-side clock and a 32-bit APB register bus.
 */
package ivn_pkg;
    // Register byte offsets on the APB.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_GEN = 8'h04;
    localparam logic [7:0] OFF_NLP = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;
    // Control register field and reset value.
    localparam int CTRL_SFRE_BIT = 0;
    localparam logic SFRE_RESET = 1'b1;
    // Nesting level pointer codes.
    localparam logic [2:0] NLP_EMPTY = 3'h5;
    localparam logic [2:0] NLP_FULL = 3'h1;
    localparam logic [2:0] NLP_BAD = 3'h0;
    // Event status bit positions.
    localparam int ST_ACC = 0;
    localparam int ST_OVF = 1;
    localparam int ST_UNF = 2;
    localparam int ST_W = 3;
    localparam logic [ST_W-1:0] ST_RESET = 3'h0;
    // Sources, vectors and stacks.
    localparam int NSRC = 12;
    localparam logic [13:0] VEC_TOP = 14'h000C;
    localparam int STK_LEVELS = 4;
    localparam int PC_W = 14;
    localparam int ASK_DEPTH = 8;
    localparam logic [2:0] ASP_RESET = 3'h0;
    // Interrupt cycle length.
    localparam int CLK_PERIOD_NS = 100;
    localparam int INT_CYCLE_NS = 1780;
    localparam int INT_CYCLE_CYC = (INT_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Saved context: eight nibbles, window first.
    typedef struct packed {
        logic [3:0] window;
        logic [3:0] bank;
        logic [11:0] index;
        logic [7:0] pointer;
        logic [3:0] psw;
    } ivn_ctx_t;

    // APB request signals from the master.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ivn_apb_req_t;

    // Interrupt cycle sequencer states, Gray coded.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CYCLE = 2'b01
    } ivn_state_t;
endpackage

// ===== src/ivn_unit.sv
/*
 * Interrupt vector and nesting unit: priority pick, vector load, context
 * stack, nesting pointer, return address stack, global enable and APB regs.
 * Assumes the core gives one-cycle strobes per instruction and for EI, DI and
 * INTERRUPT_RETURN_OP, and that request inputs are already gated by the per-source enables.
 */
// The APB register port was decided locally.
// Functional notes
// - Accepted source loads PC with vector 00CH for CE down to 001H for serial 1.
// - Acceptance pushes window, bank, index, pointer and status, not the address register.
// - After the push bank, index, pointer and status clear; window stays.
// - Context stack holds four levels of eight nibbles each.
// - Interrupt return restores the top stack entry into the system registers.
// - Stack is undefined at power-on and kept through CE reset and clock stop.
// - Nesting pointer reads at 08H, ignores writes, top bit reads zero.
// - Pointer codes 101 none down to 001 four levels; power-on and watchdog set 101.
// - A fifth nested acceptance discards the earliest saved context.
// - Level-5 acceptance requests system reset only while the fault reset enable is one.
// - Fault reset enable is one after reset and takes only the first write.
// - Acceptance decrements the address stack pointer and stores PC there.
// - Return reloads PC from the selected address entry, then increments the pointer.
// - One global enable gates all twelve sources; EI sets it, DI clears it.
// - EI takes effect at the next instruction; DI clears during its own cycle.
// - Acceptance clears the global enable.
// - Global enable clears on every reset except clock stop.
// - Fixed priority: CE, pins 0 to 4, timers 0 to 3, serial 0, serial 1.
// - Acceptance clears the source request and global enable in one interrupt cycle.
`timescale 1ns/1ps
module ivn_unit
    import ivn_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire ivn_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [NSRC-1:0] src_req,
    input wire logic instr_cycle,
    input wire logic enable_interrupts_op,
    input wire logic mask_all_op,
    input wire logic interrupt_return_op,
    input wire logic rst_wdt_stack,
    input wire logic rst_pin,
    input wire logic rst_ce,
    input wire logic [PC_W-1:0] pc_in,
    input wire ivn_ctx_t ctx_in,
    output logic [NSRC-1:0] src_clear,
    output logic accept,
    output logic int_busy,
    output logic pc_load,
    output logic [PC_W-1:0] pc_out,
    output logic ctx_load,
    output ivn_ctx_t ctx_out,
    output logic sys_reset_req,
    output logic global_irq_enable
);

    // Index of the highest-priority set bit; bit 0 is the CE source.
    function automatic logic [3:0] pick_idx(input logic [NSRC-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Vector for a source index: highest priority gets the top vector.
    function automatic logic [PC_W-1:0] vec_of(input logic [3:0] idx);
        return VEC_TOP - {10'h000, idx};
    endfunction

    ivn_state_t state_q, state_d;
    logic [4:0] cyc_q, cyc_d;
    logic ge_q, ge_d, ei_pend_q, ei_pend_d;
    logic [2:0] nlp_q, nlp_d;
    ivn_ctx_t stk_q [STK_LEVELS], stk_d [STK_LEVELS];
    logic [PC_W-1:0] ask_q [ASK_DEPTH], ask_d [ASK_DEPTH];
    logic [2:0] asp_q, asp_d;
    logic sfre_q, sfre_d, sfre_lock_q, sfre_lock_d;
    logic [ST_W-1:0] stat_q, stat_d, mask_q, mask_d;
    logic [NSRC-1:0] src_clear_q, src_clear_d;
    logic accept_q, accept_d, pc_load_q, pc_load_d, ctx_load_q, ctx_load_d;
    logic [PC_W-1:0] pc_out_q, pc_out_d;
    ivn_ctx_t ctx_out_q, ctx_out_d;
    logic sys_reset_q, sys_reset_d, irq_q, irq_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic any_rst, take, do_ret, apb_done, apb_wr, apb_rd, mapped;
    logic [3:0] win_idx;

    // Acceptance happens at an instruction boundary; DI in the same cycle
    // wins because it clears the enable during its own execution.
    assign any_rst = rst_wdt_stack || rst_pin || rst_ce;
    assign win_idx = pick_idx(src_req);
    assign do_ret = interrupt_return_op && state_q == ST_IDLE && !any_rst;
    assign take = instr_cycle && ge_q && !mask_all_op && (|src_req) && !do_ret
        && state_q == ST_IDLE && !any_rst;

    // Sequencer, global enable and nesting pointer.
    always_comb begin
        state_d = state_q;
        cyc_d = cyc_q;
        ge_d = ge_q;
        ei_pend_d = ei_pend_q;
        nlp_d = nlp_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_CYCLE;
                    cyc_d = 5'(INT_CYCLE_CYC - 1);
                end
            end
            ST_CYCLE: begin
                if (cyc_q == 5'h00) begin
                    state_d = ST_IDLE;
                end else begin
                    cyc_d = cyc_q - 5'h01;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (enable_interrupts_op) begin
            ei_pend_d = 1'b1;
        end else if (instr_cycle && ei_pend_q) begin
            ge_d = 1'b1;
            ei_pend_d = 1'b0;
        end
        if (mask_all_op) begin
            ge_d = 1'b0;
            ei_pend_d = 1'b0;
        end
        if (take) begin
            ge_d = 1'b0;
            if (nlp_q != NLP_FULL) begin
                nlp_d = nlp_q - 3'h1;
            end
        end else if (do_ret && nlp_q != NLP_EMPTY) begin
            nlp_d = nlp_q + 3'h1;
        end
        if (any_rst) begin
            ge_d = 1'b0;
            ei_pend_d = 1'b0;
            state_d = ST_IDLE;
        end
        if (rst_wdt_stack) begin
            nlp_d = NLP_EMPTY;
        end
    end

    // Control flops; clock stop simply freezes the clock, so all state holds.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cyc_q <= 5'h00;
            ge_q <= 1'b0;
            ei_pend_q <= 1'b0;
            nlp_q <= NLP_EMPTY;
        end else begin
            state_q <= state_d;
            cyc_q <= cyc_d;
            ge_q <= ge_d;
            ei_pend_q <= ei_pend_d;
            nlp_q <= nlp_d;
        end
    end

    // Context stack as a shift stack: entry 0 is the newest save. A push
    // when full shifts the oldest entry out, which is what discards it.
    always_comb begin
        stk_d = stk_q;
        if (take) begin
            stk_d[0] = ctx_in;
            for (int i = 1; i < STK_LEVELS; i++) begin
                stk_d[i] = stk_q[i-1];
            end
        end else if (do_ret) begin
            for (int i = 0; i < STK_LEVELS - 1; i++) begin
                stk_d[i] = stk_q[i+1];
            end
        end
    end

    // No reset on the stacks: contents are undefined at power-on and
    // survive CE reset and clock stop.
    always_ff @(posedge pclk) begin
        stk_q <= stk_d;
        ask_q <= ask_d;
    end

    // Return address stack: pre-decrement on accept, post-increment on return.
    always_comb begin
        ask_d = ask_q;
        asp_d = asp_q;
        if (take) begin
            asp_d = asp_q - 3'h1;
            ask_d[asp_q - 3'h1] = pc_in;
        end else if (do_ret) begin
            asp_d = asp_q + 3'h1;
        end
        if (rst_wdt_stack || rst_pin) begin
            asp_d = ASP_RESET;
        end
    end

    // Core-facing outputs. Any request cleared by an acceptance is reported
    // one-hot so the request block drops exactly the winner.
    always_comb begin
        accept_d = take;
        src_clear_d = '0;
        pc_load_d = 1'b0;
        pc_out_d = pc_out_q;
        ctx_load_d = 1'b0;
        ctx_out_d = ctx_out_q;
        sys_reset_d = 1'b0;
        if (take) begin
            src_clear_d[win_idx] = 1'b1;
            pc_load_d = 1'b1;
            pc_out_d = vec_of(win_idx);
            ctx_load_d = 1'b1;
            ctx_out_d = '0;
            ctx_out_d.window = ctx_in.window;
            sys_reset_d = (nlp_q == NLP_FULL) && sfre_q;
        end else if (do_ret) begin
            pc_load_d = 1'b1;
            pc_out_d = ask_q[asp_q];
            ctx_load_d = 1'b1;
            ctx_out_d = stk_q[0];
            sys_reset_d = (nlp_q == NLP_EMPTY) && sfre_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            asp_q <= ASP_RESET;
            accept_q <= 1'b0;
            src_clear_q <= '0;
            pc_load_q <= 1'b0;
            pc_out_q <= '0;
            ctx_load_q <= 1'b0;
            ctx_out_q <= '0;
            sys_reset_q <= 1'b0;
        end else begin
            asp_q <= asp_d;
            accept_q <= accept_d;
            src_clear_q <= src_clear_d;
            pc_load_q <= pc_load_d;
            pc_out_q <= pc_out_d;
            ctx_load_q <= ctx_load_d;
            ctx_out_q <= ctx_out_d;
            sys_reset_q <= sys_reset_d;
        end
    end

    // APB slave: one wait state, so every output comes from a flop.
    assign apb_done = apb_req.psel && apb_req.penable && pready_q;
    assign apb_wr = apb_done && apb_req.pwrite;
    assign apb_rd = apb_done && !apb_req.pwrite;
    assign mapped = apb_req.paddr inside {OFF_CTRL, OFF_GEN, OFF_NLP, OFF_STAT, OFF_MASK};

    always_comb begin
        pready_d = apb_req.psel && apb_req.penable && !pready_q;
        pslverr_d = pready_d && !mapped;
        prdata_d = prdata_q;
        if (pready_d) begin
            case (apb_req.paddr)
                OFF_CTRL: prdata_d = {31'h0, sfre_q};
                OFF_GEN: prdata_d = {29'h0, asp_q == ASP_RESET, ei_pend_q, ge_q};
                OFF_NLP: prdata_d = {29'h0, nlp_q};
                OFF_STAT: prdata_d = {29'h0, stat_q};
                OFF_MASK: prdata_d = {29'h0, mask_q};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Register state. Writes to the nesting pointer fall through unused.
    // The fault reset enable locks after its first write until system reset.
    always_comb begin
        sfre_d = sfre_q;
        sfre_lock_d = sfre_lock_q;
        mask_d = mask_q;
        stat_d = stat_q;
        if (apb_wr && apb_req.paddr == OFF_CTRL && !sfre_lock_q) begin
            sfre_d = apb_req.pwdata[CTRL_SFRE_BIT];
            sfre_lock_d = 1'b1;
        end
        if (apb_wr && apb_req.paddr == OFF_MASK) begin
            mask_d = apb_req.pwdata[ST_W-1:0];
        end
        if (apb_rd && apb_req.paddr == OFF_STAT) begin
            stat_d = ST_RESET;
        end
        // Setting after the read clear lets a same-cycle event survive.
        if (take) begin
            stat_d[ST_ACC] = 1'b1;
            stat_d[ST_OVF] = stat_d[ST_OVF] | (nlp_q == NLP_FULL);
        end
        if (do_ret && nlp_q == NLP_EMPTY) begin
            stat_d[ST_UNF] = 1'b1;
        end
        if (rst_wdt_stack || rst_pin) begin
            sfre_d = SFRE_RESET;
            sfre_lock_d = 1'b0;
        end
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sfre_q <= SFRE_RESET;
            sfre_lock_q <= 1'b0;
            mask_q <= ST_RESET;
            stat_q <= ST_RESET;
            irq_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            sfre_q <= sfre_d;
            sfre_lock_q <= sfre_lock_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            irq_q <= irq_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign src_clear = src_clear_q;
    assign accept = accept_q;
    assign int_busy = (state_q == ST_CYCLE);
    assign pc_load = pc_load_q;
    assign pc_out = pc_out_q;
    assign ctx_load = ctx_load_q;
    assign ctx_out = ctx_out_q;
    assign sys_reset_req = sys_reset_q;
    assign global_irq_enable = ge_q;

    // Checks on the unit's own outputs and state.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    vector_on_accept_a: assert property (accept_q |->
        (src_clear_q == (12'h001 << (VEC_TOP - pc_out_q))) && pc_load_q)
        else $error("vector does not match the cleared source");
    context_cleared_a: assert property (accept_q |-> ctx_out_q.bank == 4'h0
        && ctx_out_q.index == 12'h000 && ctx_out_q.pointer == 8'h00 && ctx_out_q.psw == 4'h0)
        else $error("context not cleared on acceptance");
    nest_push_a: assert property (take && nlp_q != NLP_FULL && !rst_wdt_stack
        |=> nlp_q == $past(nlp_q) - 3'h1)
        else $error("nesting pointer did not step down");
    nest_legal_a: assert property (nlp_q != NLP_BAD && nlp_q <= NLP_EMPTY)
        else $error("nesting pointer holds an illegal code");
    enable_drop_a: assert property (take ##1 accept_q |-> !ge_q)
        else $error("global enable survived acceptance");
    mask_all_a: assert property (mask_all_op |=> !ge_q)
        else $error("mask-all did not clear the enable");
    ei_defer_a: assert property (enable_interrupts_op && !ge_q |=> !ge_q)
        else $error("enable took effect too early");
    return_pop_a: assert property (do_ret && !rst_wdt_stack && !rst_pin
        |=> asp_q == $past(asp_q) + 3'h1 && pc_load_q)
        else $error("return did not step the address pointer");
    fault_once_a: assert property (sfre_lock_q && !rst_wdt_stack && !rst_pin
        |=> $stable(sfre_q))
        else $error("fault reset enable changed after lock");
    level_five_a: assert property (take && nlp_q == NLP_FULL && sfre_q
        |=> sys_reset_q ##1 !sys_reset_q)
        else $error("level five acceptance without reset request");
    cycle_len_a: assert property (accept_q |-> int_busy [*8])
        else $error("interrupt cycle ended early");

endmodule // ivn_unit

// ===== test/ivn_core_model.sv
/*
 * Behavioural model of the core sequencer and of the peripheral request flags.
 * Assumes the unit's load and clear outputs are one-cycle pulses and that the
 * bench sets the core's PC and context through the write strobe.
 */
`timescale 1ns/1ps
module ivn_core_model
    import ivn_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NSRC-1:0] req_set,
    input wire logic [NSRC-1:0] src_clear,
    input wire logic core_wr,
    input wire logic [PC_W-1:0] core_pc,
    input wire ivn_ctx_t core_ctx,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_out,
    input wire logic ctx_load,
    input wire ivn_ctx_t ctx_out,
    output logic [NSRC-1:0] src_req,
    output logic [PC_W-1:0] pc_in,
    output ivn_ctx_t ctx_in
);
    // A flag stays pending until the unit names it; a new event wins over a clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_req <= '0;
        end else begin
            src_req <= (src_req & ~src_clear) | req_set;
        end
    end
    // The core takes a vector, return address or context the cycle it is loaded.
    always_ff @(posedge pclk) begin
        if (pc_load) begin
            pc_in <= pc_out;
        end else if (core_wr) begin
            pc_in <= core_pc;
        end
        if (ctx_load) begin
            ctx_in <= ctx_out;
        end else if (core_wr) begin
            ctx_in <= core_ctx;
        end
    end
endmodule // ivn_core_model

// ===== test/testbench.sv
/*
 * Self-checking bench of the interrupt vector and nesting unit.
 * Assumes ivn_pkg, ivn_unit and ivn_core_model are compiled before it.
 */
`timescale 1ns/1ps
module testbench;
    import ivn_pkg::*;
    typedef struct packed {
        logic [11:0] req;
        logic [13:0] vec;
        logic [11:0] clr;
    } ivn_row_t;
    localparam int I_INS = 0;
    localparam int I_EI = 1;
    localparam int I_DI = 2;
    localparam int I_RET = 3;
    localparam int I_WDT = 4;
    localparam int I_PIN = 5;
    localparam int I_CE = 6;
    localparam logic [31:0] CTX_A = 32'hA9876543;
    logic pclk, presetn, pready, pslverr, irq, accept, int_busy, pc_load, ctx_load;
    logic sys_reset_req, global_irq_enable, core_wr;
    logic [6:0] op;
    logic [31:0] prdata;
    logic [11:0] src_req, src_clear, req_set;
    logic [13:0] pc_out, pc_in, core_pc;
    ivn_apb_req_t req;
    ivn_ctx_t ctx_in, ctx_out, core_ctx, cur;
    ivn_row_t rows [NSRC];
    int errors = 0;
    int compares = 0;

    ivn_unit dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .src_req(src_req),
        .instr_cycle(op[I_INS]), .enable_interrupts_op(op[I_EI]), .mask_all_op(op[I_DI]),
        .interrupt_return_op(op[I_RET]), .rst_wdt_stack(op[I_WDT]), .rst_pin(op[I_PIN]),
        .rst_ce(op[I_CE]), .pc_in(pc_in), .ctx_in(ctx_in), .src_clear(src_clear),
        .accept(accept), .int_busy(int_busy), .pc_load(pc_load), .pc_out(pc_out),
        .ctx_load(ctx_load), .ctx_out(ctx_out), .sys_reset_req(sys_reset_req),
        .global_irq_enable(global_irq_enable));
    ivn_core_model core_u (.pclk(pclk), .presetn(presetn), .req_set(req_set),
        .src_clear(src_clear), .core_wr(core_wr), .core_pc(core_pc), .core_ctx(core_ctx),
        .pc_load(pc_load), .pc_out(pc_out), .ctx_load(ctx_load), .ctx_out(ctx_out),
        .src_req(src_req), .pc_in(pc_in), .ctx_in(ctx_in));

    // Verdict in one place; the apb ready and load pulse timeouts end here too.
    task automatic complete_run;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_b(input string nm, input logic e, input logic g);
        chk_w(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic fail_out(input string nm);
        errors++;
        $display("[FAIL] %s expected 1 seen 0", nm);
        complete_run();
    endtask
    // APB master: the request is held until pready is sampled high at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 10);
        rd = prdata;
        er = pslverr;
        req <= '0;
        if (n >= 10) begin
            fail_out("apb ready");
        end
    endtask
    task automatic apb_rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] d;
        logic r;
        apb(1'b0, a, 32'h0, d, r);
        chk_w($sformatf("read %h", a), e, d);
        chk_b("slave error", ee, r);
    endtask
    task automatic apb_wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic r;
        apb(1'b1, a, wd, d, r);
    endtask
    task automatic pulse(input int b);
        @(posedge pclk);
        op <= 7'h01 << b;
        @(posedge pclk);
        op <= 7'h00;
    endtask
    task automatic load_core(input logic [13:0] pc, input ivn_ctx_t c, input logic [11:0] rs);
        @(posedge pclk);
        core_wr <= 1'b1;
        core_pc <= pc;
        core_ctx <= c;
        req_set <= rs;
        cur = c;
        @(posedge pclk);
        core_wr <= 1'b0;
        req_set <= '0;
    endtask
    // The load pulse stands for one cycle from the edge that ends the strobe.
    // So look in that cycle first, and only then wait for later edges.
    task automatic wait_load;
        int n;
        n = 0;
        #1;
        while (pc_load !== 1'b1 && n < 8) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (pc_load !== 1'b1) begin
            fail_out("load pulse");
        end
    endtask
    // Enable, let the next instruction arm it, then take the top pending source.
    task automatic take_irq(input logic [13:0] vec, input logic [11:0] clr, input logic rq);
        int n;
        pulse(I_EI);
        #1;
        chk_b("enable after EI", 1'b0, global_irq_enable);
        pulse(I_INS);
        #1;
        chk_b("enable at next instr", 1'b1, global_irq_enable);
        pulse(I_INS);
        wait_load();
        chk_b("accept", 1'b1, accept);
        chk_b("context load", 1'b1, ctx_load);
        chk_w("vector", 32'(vec), 32'(pc_out));
        chk_w("request clear", 32'(clr), 32'(src_clear));
        chk_b("enable after accept", 1'b0, global_irq_enable);
        chk_w("cleared context", {cur.window, 28'h0}, ctx_out);
        chk_b("system reset", rq, sys_reset_req);
        n = 0;
        while (int_busy === 1'b1 && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk_w("busy cycles", INT_CYCLE_CYC, n);
    endtask
    task automatic ret_irq(input logic [13:0] pc, input ivn_ctx_t c);
        pulse(I_RET);
        wait_load();
        chk_w("return address", 32'(pc), 32'(pc_out));
        chk_b("context load", 1'b1, ctx_load);
        chk_w("restored context", c, ctx_out);
    endtask
    // Five nested levels; the earliest context is lost, the rest come back in order.
    task automatic nest(input logic rq);
        for (int k = 0; k < 5; k++) begin
            load_core(14'(12'h200 + k), ivn_ctx_t'({4'(k), 28'h1234567}), 12'h800);
            take_irq(14'h001, 12'h800, rq && k == 4);
            apb_rd(OFF_NLP, (k < 4) ? 32'(4 - k) : 32'h1, 1'b0);
        end
        for (int k = 4; k > 0; k--) begin
            ret_irq(14'(12'h200 + k), ivn_ctx_t'({4'(k), 28'h1234567}));
        end
        apb_rd(OFF_NLP, 32'h5, 1'b0);
    endtask

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        req = '0;
        op = '0;
        req_set = '0;
        core_wr = 1'b0;
        core_pc = '0;
        core_ctx = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Each row leaves all sources from this one downward pending at once.
        for (int i = 0; i < NSRC; i++) begin
            rows[i] = '{12'hFFF << i, 14'(12 - i), 12'h001 << i};
        end
        foreach (rows[i]) begin
            load_core(14'(12'h100 + i), CTX_A, rows[i].req);
            take_irq(rows[i].vec, rows[i].clr, 1'b0);
            apb_rd(OFF_NLP, 32'h4, 1'b0);
            ret_irq(14'(12'h100 + i), CTX_A);
            apb_rd(OFF_NLP, 32'h5, 1'b0);
            $display("row %0d done", i);
        end
        apb_rd(OFF_CTRL, 32'h1, 1'b0);
        apb_rd(OFF_MASK, 32'h0, 1'b0);
        apb_rd(8'h20, 32'h0, 1'b1);
        apb_wr(OFF_NLP, 32'h0);
        apb_rd(OFF_NLP, 32'h5, 1'b0);
        apb_rd(OFF_STAT, 32'h1, 1'b0);
        apb_rd(OFF_STAT, 32'h0, 1'b0);
        $display("register test done");
        // Without the global enable a pending source is never taken.
        load_core(14'h300, CTX_A, 12'h001);
        pulse(I_INS);
        pulse(I_INS);
        repeat (3) @(posedge pclk);
        chk_w("still pending", 32'h1, 32'(src_req));
        apb_wr(OFF_MASK, 32'h1);
        take_irq(14'h00C, 12'h001, 1'b0);
        chk_b("irq", 1'b1, irq);
        apb_rd(OFF_STAT, 32'h1, 1'b0);
        repeat (2) @(posedge pclk);
        #1;
        chk_b("irq after read", 1'b0, irq);
        // Each reset kind and DI drop the enable; CE reset keeps the stack.
        for (int j = 0; j < 4; j++) begin
            pulse(I_EI);
            pulse(I_INS);
            pulse(j == 0 ? I_CE : j == 1 ? I_DI : j == 2 ? I_WDT : I_PIN);
            #1;
            chk_b("enable cleared", 1'b0, global_irq_enable);
            if (j == 0) begin
                ret_irq(14'h300, CTX_A);
            end
        end
        $display("enable test done");
        nest(1'b1);
        pulse(I_WDT);
        apb_wr(OFF_CTRL, 32'h0);
        apb_rd(OFF_CTRL, 32'h0, 1'b0);
        apb_wr(OFF_CTRL, 32'h1);
        apb_rd(OFF_CTRL, 32'h0, 1'b0);
        nest(1'b0);
        $display("nesting test done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb_rd(OFF_CTRL, 32'h1, 1'b0);
        apb_rd(OFF_NLP, 32'h5, 1'b0);
        chk_b("enable after reset", 1'b0, global_irq_enable);
        $display("reset test done");
        complete_run();
    end
endmodule // testbench
